// ### can_transceiver_host.sv
// controller side of a high-speed can transceiver: txd, mode select, rxd
`timescale 1ns/10ps
`include "can_host_defines.svh"
module can_transceiver_host #(
    parameter int BIT_CYCLES = `CAN_MIN_BIT_CYCLES
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic tx_valid_i,
    input wire logic tx_bit_i,
    input wire logic [1:0] mode_req_i,
    input wire logic rxd_i,
    output logic txd_o,
    output logic [1:0] mode_select_input_o,
    output logic tx_taken_o,
    output logic tx_refused_o,
    output logic rx_bit_o,
    output logic wake_o
);
    // clamp the bit time into the legal window so a bad parameter cannot break the bus
    localparam int BIT_LO = (BIT_CYCLES < `CAN_MIN_BIT_CYCLES) ? `CAN_MIN_BIT_CYCLES : BIT_CYCLES;
    localparam int BIT_EFF = (BIT_LO > `CAN_MAX_BIT_CYCLES) ? `CAN_MAX_BIT_CYCLES : BIT_LO;
    localparam int DOM_LIMIT = `CAN_MAX_DOM_BITS;

    logic rst_meta;
    logic rst_n;
    logic bit_strobe;
    logic [4:0] dom_run;
    can_host_pkg::mode_type mode;
    can_host_pkg::mode_type next_mode;

    // reset release through two flops; async assert
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    can_bit_timer #(
        .CYCLES(BIT_EFF)
    ) u_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .strobe_o(bit_strobe)
    );

    // decode the requested mode; unknown codes fall back to standby, the quiet choice
    always_comb begin
        case (mode_req_i)
            `CAN_MODE_HIGH_SPEED: next_mode = can_host_pkg::MODE_HIGH_SPEED;
            `CAN_MODE_SLOPE: next_mode = can_host_pkg::MODE_SLOPE;
            default: next_mode = can_host_pkg::MODE_STANDBY;
        endcase
    end

    // mode pin level; ground level selects the fast edges
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mode <= can_host_pkg::MODE_STANDBY;
            mode_select_input_o <= `CAN_MODE_STANDBY;
        end else begin
            mode <= next_mode;
            case (next_mode)
                can_host_pkg::MODE_HIGH_SPEED: mode_select_input_o <= `CAN_MODE_HIGH_SPEED; // RQ6
                can_host_pkg::MODE_SLOPE: mode_select_input_o <= `CAN_MODE_SLOPE;
                default: mode_select_input_o <= `CAN_MODE_STANDBY;
            endcase
        end
    end

    // transmit one bit per strobe; bit time kept within 1 Mb/s and 16 kb/s bounds
    // dominant runs are capped so the transceiver's txd timeout never trips
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            txd_o <= 1'b1;
            dom_run <= '0;
            tx_taken_o <= 1'b0;
            tx_refused_o <= 1'b0;
        end else begin
            tx_taken_o <= 1'b0;
            tx_refused_o <= 1'b0;
            if (mode == can_host_pkg::MODE_STANDBY) begin
                txd_o <= 1'b1; // RQ8
                dom_run <= '0;
            end else if (bit_strobe) begin // RQ15
                if (tx_valid_i && !tx_bit_i && dom_run < 5'(DOM_LIMIT)) begin
                    txd_o <= 1'b0;
                    dom_run <= dom_run + 5'h1; // RQ14
                    tx_taken_o <= 1'b1;
                end else begin
                    txd_o <= 1'b1;
                    dom_run <= '0;
                    tx_taken_o <= tx_valid_i && tx_bit_i;
                    tx_refused_o <= tx_valid_i && !tx_bit_i; // RQ14
                end
            end
        end
    end

    // receive path and wake detection; rxd treated as synchronous to clk_i
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_bit_o <= 1'b1;
            wake_o <= 1'b0;
        end else begin
            rx_bit_o <= rxd_i;
            // first dominant seen in standby tells software the bus is busy
            wake_o <= (mode == can_host_pkg::MODE_STANDBY) && rx_bit_o && !rxd_i; // RQ8
        end
    end

    // helper counters for the checks below
    logic [`CAN_TIMER_WIDTH-1:0] since_chg;
    logic [15:0] low_cycles;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            since_chg <= '1;
            low_cycles <= '0;
        end else begin
            if (txd_o != $past(txd_o)) begin
                since_chg <= '0;
            end else if (since_chg != '1) begin
                since_chg <= since_chg + `CAN_TIMER_WIDTH'(1);
            end
            low_cycles <= txd_o ? 16'h0 : low_cycles + 16'h1;
        end
    end

    property p_min_bit_time;
        @(posedge clk_i) disable iff (!rst_n)
        $changed(txd_o) |-> (since_chg >= `CAN_TIMER_WIDTH'(BIT_EFF - 1));
    endproperty
    a_min_bit_time: assert property (p_min_bit_time) else $error("txd changed faster than one bit time"); // RQ15

    property p_dom_limit;
        @(posedge clk_i) disable iff (!rst_n)
        dom_run <= 5'(DOM_LIMIT);
    endproperty
    a_dom_limit: assert property (p_dom_limit) else $error("dominant run past limit"); // RQ14

    property p_low_time;
        @(posedge clk_i) disable iff (!rst_n)
        !txd_o |-> (32'(low_cycles) < DOM_LIMIT * BIT_EFF);
    endproperty
    a_low_time: assert property (p_low_time) else $error("txd low long enough to trip timeout"); // RQ14

    property p_high_speed_ground;
        @(posedge clk_i) disable iff (!rst_n)
        (mode_req_i == `CAN_MODE_HIGH_SPEED) |=> (mode_select_input_o == `CAN_MODE_HIGH_SPEED);
    endproperty
    a_high_speed_ground: assert property (p_high_speed_ground) else $error("high-speed not at ground level"); // RQ6

    property p_standby_quiet;
        @(posedge clk_i) disable iff (!rst_n)
        (mode == can_host_pkg::MODE_STANDBY) |=> txd_o;
    endproperty
    a_standby_quiet: assert property (p_standby_quiet) else $error("txd dominant in standby"); // RQ8

    property p_wake;
        @(posedge clk_i) disable iff (!rst_n)
        ((mode == can_host_pkg::MODE_STANDBY) && rx_bit_o && !rxd_i) |=> wake_o ##1 !wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("missed wake pulse"); // RQ8

    // a bit is either taken or refused, never both on one strobe
    property p_take_or_refuse;
        @(posedge clk_i) disable iff (!rst_n)
        !(tx_taken_o && tx_refused_o);
    endproperty
    a_take_or_refuse: assert property (p_take_or_refuse) else $error("bit both taken and refused"); // RQ14

    // a refused dominant bit must leave the line recessive
    property p_refused_recessive;
        @(posedge clk_i) disable iff (!rst_n)
        tx_refused_o |-> txd_o;
    endproperty
    a_refused_recessive: assert property (p_refused_recessive) else $error("refused bit not recessive"); // RQ14

    // a taken bit shows the value offered at the strobe
    property p_taken_bit;
        @(posedge clk_i) disable iff (!rst_n)
        tx_taken_o |-> (txd_o == $past(tx_bit_i));
    endproperty
    a_taken_bit: assert property (p_taken_bit) else $error("taken bit differs from offered bit"); // RQ15

    // one bit per strobe, so the taken pulse never lasts two cycles
    property p_one_take;
        @(posedge clk_i) disable iff (!rst_n)
        tx_taken_o |=> !tx_taken_o;
    endproperty
    a_one_take: assert property (p_one_take) else $error("taken pulse longer than one cycle"); // RQ15

    // strobes stay well apart; a short gap would push the bit rate past the bus limit
    property p_strobe_gap;
        @(posedge clk_i) disable iff (!rst_n)
        bit_strobe |=> !bit_strobe [*8];
    endproperty
    a_strobe_gap: assert property (p_strobe_gap) else $error("bit strobes too close"); // RQ15

    // standby takes nothing and refuses nothing
    property p_standby_silent;
        @(posedge clk_i) disable iff (!rst_n)
        (mode == can_host_pkg::MODE_STANDBY) |=> (!tx_taken_o && !tx_refused_o);
    endproperty
    a_standby_silent: assert property (p_standby_silent) else $error("bit handled in standby"); // RQ8

    // slope request reaches the pin as the mid level
    property p_slope_mid;
        @(posedge clk_i) disable iff (!rst_n)
        (mode_req_i == `CAN_MODE_SLOPE) |=> (mode_select_input_o == `CAN_MODE_SLOPE);
    endproperty
    a_slope_mid: assert property (p_slope_mid) else $error("slope not at mid level"); // RQ6

    // both upper codes park the transceiver in standby
    property p_standby_high;
        @(posedge clk_i) disable iff (!rst_n)
        mode_req_i[1] |=> (mode_select_input_o == `CAN_MODE_STANDBY);
    endproperty
    a_standby_high: assert property (p_standby_high) else $error("standby not at high level"); // RQ8

    // receive data follows rxd one clock later; skipped on the first edge out of reset
    property p_rx_follow;
        @(posedge clk_i) disable iff (!rst_n)
        $past(rst_n) |-> (rx_bit_o == $past(rxd_i));
    endproperty
    a_rx_follow: assert property (p_rx_follow) else $error("receive bit does not follow rxd"); // RQ8
endmodule

// ### can_host_defines.svh
// constants for the controller that drives a high-speed can transceiver
// What this block does
// RQ1 - transceiver: txd low dominant, high recessive
// RQ2 - transceiver: other node's dominant beats recessive
// RQ3 - transceiver: rxd low dominant, high recessive
// RQ4 - transceiver: over-temperature disables only bus drivers
// RQ5 - transceiver: mode pin picks standby, slope, high-speed
// RQ6 - controller grounds mode pin for high-speed
// RQ7 - transceiver: standby transmitter off, receiver slower
// RQ8 - controller watches rxd in standby, then wakes
// RQ9 - transceiver: bus floats until upper power-on threshold
// RQ10 - transceiver: txd low at power-on keeps bus floating
// RQ11 - transceiver: supply below lower threshold floats bus
// RQ12 - transceiver: txd low over 1.25 ms disables drivers
// RQ13 - transceiver: txd rising edge clears timeout
// RQ14 - bit time max 62.5 us, 20 dominant
// RQ15 - bit rate at most 1 Mb/s
// RQ16 - transceiver: low supply still follows truth table
// RQ17 - transceiver: floating txd reads as recessive
// RQ18 - transceiver model: conditions as inputs, clocked timeout
`ifndef CAN_HOST_DEFINES_SVH
`define CAN_HOST_DEFINES_SVH

`define CAN_CLK_PERIOD_PS 25000
`define CAN_MIN_BIT_PS 1000000
`define CAN_MAX_BIT_PS 62500000
`define CAN_MIN_BIT_CYCLES ((`CAN_MIN_BIT_PS + `CAN_CLK_PERIOD_PS - 1) / `CAN_CLK_PERIOD_PS)
`define CAN_MAX_BIT_CYCLES (`CAN_MAX_BIT_PS / `CAN_CLK_PERIOD_PS)
`define CAN_MAX_DOM_BITS 20
`define CAN_TIMER_WIDTH 12
`define CAN_MODE_HIGH_SPEED 2'h0
`define CAN_MODE_SLOPE 2'h1
`define CAN_MODE_STANDBY 2'h3
// stuck-low txd limit of the transceiver, 1.25 ms of the reference clock
`define CAN_DOM_TIMEOUT_CYCLES 50000

`endif

// ### can_host_pkg.sv
// types shared by the transceiver controller
package can_host_pkg;
    typedef enum logic [1:0] {
        MODE_HIGH_SPEED,
        MODE_SLOPE,
        MODE_STANDBY
    } mode_type;
endpackage

// ### can_bit_timer.sv
// free-running bit period counter giving one strobe per bit time
`timescale 1ns/10ps
`include "can_host_defines.svh"
module can_bit_timer #(
    parameter int CYCLES = 40
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    output logic strobe_o
);
    logic [`CAN_TIMER_WIDTH-1:0] count;

    // count down and pulse once per period
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= '0;
            strobe_o <= 1'b0;
        end else if (count == '0) begin
            count <= `CAN_TIMER_WIDTH'(CYCLES - 1);
            strobe_o <= 1'b1;
        end else begin
            count <= count - `CAN_TIMER_WIDTH'(1);
            strobe_o <= 1'b0;
        end
    end
endmodule

// ### can_xcvr_model.sv
// behavioural transceiver model: bus state, receive data, standby, protection, dominant timeout
`timescale 1ns/10ps
`include "can_host_defines.svh"
module can_xcvr_model #(
    parameter int TIMEOUT_CYCLES = `CAN_DOM_TIMEOUT_CYCLES
) (
    input wire logic clk_i,
    input wire logic txd_i,
    input wire logic [1:0] mode_pin_i,
    input wire logic other_dom_i,
    input wire logic over_temp_i,
    input wire logic supply_up_i,
    input wire logic supply_down_i,
    output logic bus_dom_o,
    output logic rxd_o
);
    int low_cnt = 0;
    logic txd_hi;
    logic powered = 1'b0;
    logic drive;
    // an open or high txd reads as recessive, as the pull-up would make it
    assign txd_hi = (txd_i !== 1'b0);
    // low time of txd counted on the reference clock, any high level clears it
    always_ff @(posedge clk_i) low_cnt <= txd_hi ? 0 : low_cnt + 1;
    // bus floats until the upper threshold is met with txd high; brown-out floats it again
    always_ff @(posedge clk_i) begin
        if (supply_down_i) begin
            powered <= 1'b0;
        end else if (supply_up_i && txd_hi) begin
            powered <= 1'b1;
        end
    end
    // drivers off when unpowered, hot, in standby or after a stuck-low txd; same table at low supply
    assign drive = powered && !over_temp_i && (mode_pin_i != `CAN_MODE_STANDBY)
        && (low_cnt <= TIMEOUT_CYCLES);
    // wired bus: any dominant wins
    assign bus_dom_o = (drive && !txd_hi) || other_dom_i;
    // receiver keeps running whatever the drivers do; low while dominant
    assign rxd_o = !bus_dom_o;
endmodule

// ### testbench.sv
// self-checking bench for the transceiver controller against the transceiver model
`timescale 1ns/10ps
module testbench;
    logic clk = 0, resetn = 0, tx_valid = 0, tx_bit = 1, other_dom = 0, rxd, txd, taken, refused, rx_bit, wake;
    logic over_temp = 0, supply_up = 1, supply_down = 0, drv_off = 0, bus_dom;
    logic [1:0] mode_req = 2'h3;
    logic [1:0] mode_pin;
    int failures = 0;
    int comparisons = 0;
    always #12.5 clk = ~clk;
    can_transceiver_host #(.BIT_CYCLES(40)) can_transceiver_host_i (.clk_i(clk), .resetn_i(resetn),
        .tx_valid_i(tx_valid), .tx_bit_i(tx_bit), .mode_req_i(mode_req), .rxd_i(rxd), .txd_o(txd),
        .mode_select_input_o(mode_pin), .tx_taken_o(taken), .tx_refused_o(refused), .rx_bit_o(rx_bit), .wake_o(wake));
    can_xcvr_model can_xcvr_model_i (.clk_i(clk), .txd_i(txd), .mode_pin_i(mode_pin), .other_dom_i(other_dom),
        .over_temp_i(over_temp), .supply_up_i(supply_up), .supply_down_i(supply_down), .bus_dom_o(bus_dom),
        .rxd_o(rxd));
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (exp !== got) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // offer a bit and wait for the answer; valid stays up so bits run back to back
    task automatic send(input logic b, input logic exp_ref, input logic timed);
        int n;
        n = 0;
        @(negedge clk);
        tx_valid = 1;
        tx_bit = b;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (!(taken === 1'b1 || refused === 1'b1) && n < 100);
        if (timed) chk("bit_cycles", 8'h27, 8'(n));
        chk("txd", {7'h0, exp_ref | b}, {7'h0, txd});
        chk("refused", {7'h0, exp_ref}, {7'h0, refused});
        chk("taken", {7'h0, ~exp_ref}, {7'h0, taken});
        @(posedge clk);
        #1;
        // drv_off marks a scenario in which the transceiver must keep its drivers off
        chk("rx_bit", {7'h0, exp_ref | b | drv_off}, {7'h0, rx_bit});
    endtask
    // every mode request reaches the pin as its level code; the unused code 2 reaches it as the standby code
    task automatic t_modes();
        logic [1:0] req[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
        logic [1:0] pin[4] = '{2'h0, 2'h1, 2'h3, 2'h3};
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            mode_req = req[i];
            repeat (2) @(posedge clk);
            #1;
            chk("mode_pin", {6'h0, pin[i]}, {6'h0, mode_pin});
        end
    endtask
    // a run of twenty dominant bits is the limit, the next one goes out recessive
    task automatic t_dom_limit();
        send(1'b1, 1'b0, 1'b0);
        for (int i = 0; i < 20; i++) send(1'b0, 1'b0, 1'b1);
        send(1'b0, 1'b1, 1'b1);
        send(1'b0, 1'b0, 1'b1);
        send(1'b1, 1'b0, 1'b1);
    endtask
    // over-temperature, brown-out and power-up keep the bus undriven while reception goes on
    task automatic t_faults();
        @(negedge clk);
        over_temp = 1;
        drv_off = 1;
        send(1'b0, 1'b0, 1'b0);
        chk("bus_hot", 8'h00, {7'h0, bus_dom});
        @(negedge clk);
        other_dom = 1;
        @(posedge clk);
        #1;
        chk("rx_hot", 8'h00, {7'h0, rx_bit});
        @(negedge clk);
        other_dom = 0;
        over_temp = 0;
        supply_up = 0;
        supply_down = 1;
        send(1'b0, 1'b0, 1'b0);
        chk("bus_brownout", 8'h00, {7'h0, bus_dom});
        @(negedge clk);
        supply_down = 0;
        repeat (2) @(posedge clk);
        #1;
        chk("bus_rising", 8'h00, {7'h0, bus_dom});
        @(negedge clk);
        supply_up = 1;
        repeat (2) @(posedge clk);
        #1;
        chk("bus_txd_low", 8'h00, {7'h0, bus_dom});
        drv_off = 0;
        send(1'b1, 1'b0, 1'b0);
        send(1'b0, 1'b0, 1'b1);
        chk("bus_back", 8'h01, {7'h0, bus_dom});
        send(1'b1, 1'b0, 1'b1);
    endtask
    // standby keeps txd recessive and reports bus activity as a wake pulse
    task automatic t_standby();
        logic seen;
        seen = 0;
        @(negedge clk);
        mode_req = 2'h3;
        tx_bit = 0;
        repeat (100) begin
            @(posedge clk);
            #1;
            seen |= taken | refused;
        end
        chk("standby_txd", 8'h01, {6'h0, seen, txd});
        @(negedge clk);
        other_dom = 1;
        seen = 0;
        repeat (4) begin
            @(posedge clk);
            #1;
            seen |= wake;
        end
        chk("wake", 8'h01, {7'h0, seen});
        chk("rx_bit_dom", 8'h00, {7'h0, rx_bit});
        @(negedge clk);
        other_dom = 0;
        tx_valid = 0;
    endtask
    initial begin
        #100000;
        failures++;
        stop_test();
    end
    initial begin
        repeat (4) @(negedge clk);
        chk("reset_out", 8'hF1, {txd, mode_pin, rx_bit, wake, taken, refused, 1'b1});
        resetn = 1;
        repeat (3) @(negedge clk);
        t_modes();
        @(negedge clk);
        mode_req = 2'h0;
        t_dom_limit();
        t_faults();
        t_standby();
        stop_test();
    end
endmodule
